// >>> t0_seq_pkg.sv
// Purpose: shared constants and types of the card-side T = 0 transport sequencer
// Assumes: byte streams come from a character layer on the same clock
// Notes: Overview of operation follows
// Overview of operation
// - Case 2: data then status, else status
// - Case 3: status after all data received, or at once on an abnormal header verdict
// - Case 4 normal: 61xx, abnormal: status only
// - Fetch after case 4 behaves as case 2
// - 61xx and 6Cxx only for cases 2, 4
// - Error status may replace retrieval bytes
// - Too long request: 6C with available length
// - Exact request: data and status, or 61xx
// - Short request: data then 61 remainder
// - Case 4 done: 61xx or non-success status
package t0_seq_pkg;
	localparam int HDR_LAST = 4;
	localparam logic [7:0] PB_MORE = 8'h61;
	localparam logic [7:0] PB_WRONG_LE = 8'h6c;
	localparam logic [7:0] SW_OK1 = 8'h90;
	localparam logic [7:0] SW_OK2 = 8'h00;
	localparam logic [7:0] INS_GET_RESPONSE = 8'hc0;
	localparam logic [8:0] LEN_FULL = 9'h100;

	typedef enum logic [1:0] {
		CASE_2 = 2'h0,
		CASE_3 = 2'h1,
		CASE_4 = 2'h3
	} case_type;

	typedef struct packed {
		logic [7:0] cla;
		logic [7:0] ins;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
	} header_type;

	// Answer of the card application to a header or to received data
	typedef struct packed {
		logic valid;
		case_type kind;
		logic abnormal;
		logic [15:0] sw;
		logic [8:0] avail;
	} verdict_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_type;
endpackage : t0_seq_pkg

// >>> t0_apdu_transport_sequencer.sv
// Purpose: card-side sequencer mapping T = 0 headers onto data, procedure bytes and status
// Assumes: one application verdict per header and per received data block
// Notes: Case 1 and INS/60 pacing beyond one ACK byte are not handled
`timescale 1ns/1ns
module t0_apdu_transport_sequencer #(
	parameter logic [8:0] BUF_MAX = 9'h100
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire t0_seq_pkg::byte_type rx_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output t0_seq_pkg::header_type hdr_o,
	output logic hdr_valid_o,
	input wire t0_seq_pkg::verdict_type verdict_i,
	input wire logic app_data_valid_i,
	input wire logic [7:0] app_data_i,
	output logic app_data_ready_o,
	output t0_seq_pkg::byte_type cmd_data_o
);
	typedef enum logic [2:0] {
		ST_HDR = 3'h0,
		ST_VERDICT = 3'h1,
		ST_INS = 3'h3,
		ST_TXD = 3'h2,
		ST_RXD = 3'h6,
		ST_FINAL = 3'h7,
		ST_SW1 = 3'h5,
		ST_SW2 = 3'h4
	} state_type;

	state_type state, next_state;
	t0_seq_pkg::header_type hdr, next_hdr;
	t0_seq_pkg::case_type kind, next_kind;
	t0_seq_pkg::byte_type cmd_data, next_cmd_data;
	logic [2:0] hcnt, next_hcnt;
	logic [8:0] cnt, next_cnt;
	logic [7:0] sw1, next_sw1, sw2, next_sw2;
	logic [7:0] out_byte, next_out_byte;
	logic out_full, next_out_full;
	logic hdr_valid, next_hdr_valid;
	logic rx_after, next_rx_after;
	logic load_ok;
	logic [8:0] le, rem;
	t0_seq_pkg::case_type eff_kind;

	assign load_ok = !out_full || tx_ready_i;
	// P3 of zero asks for the full 256 bytes
	assign le = (hdr.p3 == 8'h00) ? t0_seq_pkg::LEN_FULL : {1'b0, hdr.p3};
	assign rem = verdict_i.avail - le;
	// A fetch header always runs the case 2 path
	assign eff_kind = (hdr.ins == t0_seq_pkg::INS_GET_RESPONSE) ? t0_seq_pkg::CASE_2 : verdict_i.kind;
	assign app_data_ready_o = (state == ST_TXD) && load_ok;

	always_comb begin
		next_state = state;
		next_hdr = hdr;
		next_kind = kind;
		next_hcnt = hcnt;
		next_cnt = cnt;
		next_sw1 = sw1;
		next_sw2 = sw2;
		next_out_byte = out_byte;
		next_out_full = out_full && !tx_ready_i;
		next_hdr_valid = 1'b0;
		next_rx_after = rx_after;
		next_cmd_data = '0;
		unique case (state)
			ST_HDR: begin
				if (rx_i.valid) begin
					next_hdr = {hdr[31:0], rx_i.data};
					next_hcnt = hcnt + 3'h1;
					if (hcnt == 3'(t0_seq_pkg::HDR_LAST)) begin
						next_hcnt = 3'h0;
						next_hdr_valid = 1'b1;
						next_state = ST_VERDICT;
					end
				end
			end
			ST_VERDICT: begin
				if (verdict_i.valid) begin
					next_kind = eff_kind;
					next_cnt = le;
					next_rx_after = 1'b0;
					// retrieval bytes on case 2 path only
					if (verdict_i.abnormal) begin
						{next_sw1, next_sw2} = verdict_i.sw;
						next_state = ST_SW1;
					end else if (eff_kind == t0_seq_pkg::CASE_2) begin
						if (le > verdict_i.avail) begin
							next_sw1 = t0_seq_pkg::PB_WRONG_LE;
							next_sw2 = verdict_i.avail[7:0];
							next_state = ST_SW1;
						end else if (le == verdict_i.avail) begin
							if (verdict_i.avail > BUF_MAX) begin
								next_sw1 = t0_seq_pkg::PB_MORE;
								next_sw2 = BUF_MAX[7:0];
								next_state = ST_SW1;
							end else begin
								next_sw1 = t0_seq_pkg::SW_OK1;
								next_sw2 = t0_seq_pkg::SW_OK2;
								next_state = ST_INS;
							end
						end else begin
							next_sw1 = t0_seq_pkg::PB_MORE;
							next_sw2 = rem[7:0];
							next_state = ST_INS;
						end
					end else begin
						// data phase of case 3 or 4
						next_rx_after = 1'b1;
						next_state = ST_INS;
					end
				end
			end
			ST_INS: begin
				if (load_ok) begin
					next_out_byte = hdr.ins;
					next_out_full = 1'b1;
					next_state = rx_after ? ST_RXD : ST_TXD;
				end
			end
			ST_TXD: begin
				if (app_data_valid_i && load_ok) begin
					next_out_byte = app_data_i;
					next_out_full = 1'b1;
					next_cnt = cnt - 9'h1;
					if (cnt == 9'h1) begin
						next_state = ST_SW1;
					end
				end
			end
			ST_RXD: begin
				if (rx_i.valid) begin
					next_cmd_data = rx_i;
					next_cnt = cnt - 9'h1;
					if (cnt == 9'h1) begin
						next_state = ST_FINAL;
					end
				end
			end
			ST_FINAL: begin
				if (verdict_i.valid) begin
					next_state = ST_SW1;
					if (kind == t0_seq_pkg::CASE_4 && !verdict_i.abnormal) begin
						next_sw1 = t0_seq_pkg::PB_MORE;
						next_sw2 = verdict_i.avail[7:0];
					end else begin
						{next_sw1, next_sw2} = verdict_i.sw;
					end
				end
			end
			ST_SW1: begin
				if (load_ok) begin
					next_out_byte = sw1;
					next_out_full = 1'b1;
					next_state = ST_SW2;
				end
			end
			ST_SW2: begin
				if (load_ok) begin
					next_out_byte = sw2;
					next_out_full = 1'b1;
					next_state = ST_HDR;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ST_HDR;
			hdr <= '0;
			kind <= t0_seq_pkg::CASE_2;
			hcnt <= 3'h0;
			cnt <= 9'h0;
			sw1 <= 8'h00;
			sw2 <= 8'h00;
			out_byte <= 8'h00;
			out_full <= 1'b0;
			hdr_valid <= 1'b0;
			rx_after <= 1'b0;
			cmd_data <= '0;
		end else begin
			state <= next_state;
			hdr <= next_hdr;
			kind <= next_kind;
			hcnt <= next_hcnt;
			cnt <= next_cnt;
			sw1 <= next_sw1;
			sw2 <= next_sw2;
			out_byte <= next_out_byte;
			out_full <= next_out_full;
			hdr_valid <= next_hdr_valid;
			rx_after <= next_rx_after;
			cmd_data <= next_cmd_data;
		end
	end

	assign tx_valid_o = out_full;
	assign tx_data_o = out_byte;
	assign hdr_o = hdr;
	assign hdr_valid_o = hdr_valid;
	assign cmd_data_o = cmd_data;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	logic decide2;
	assign decide2 = state == ST_VERDICT && verdict_i.valid && !verdict_i.abnormal && eff_kind == t0_seq_pkg::CASE_2;

	chk_wrong_le_resend: assert property (decide2 && le > verdict_i.avail |=> state == ST_SW1
		&& sw1 == t0_seq_pkg::PB_WRONG_LE && sw2 == $past(verdict_i.avail[7:0]))
		else $error("6C reply wrong");
	chk_exact_data_ok: assert property (decide2 && le == verdict_i.avail && verdict_i.avail <= BUF_MAX
		|=> state == ST_INS && sw1 == t0_seq_pkg::SW_OK1 && cnt == $past(le))
		else $error("exact case 2 wrong");
	chk_short_more: assert property (decide2 && le < verdict_i.avail |=> sw1 == t0_seq_pkg::PB_MORE
		&& sw2 == $past(rem[7:0]) && state == ST_INS && cnt == $past(le))
		else $error("remainder announce wrong");
	chk_abnormal_status: assert property (state == ST_VERDICT && verdict_i.valid && verdict_i.abnormal
		|=> state == ST_SW1 && {sw1, sw2} == $past(verdict_i.sw))
		else $error("abnormal status not passed");
	chk_case4_fetch: assert property (state == ST_FINAL && verdict_i.valid && kind == t0_seq_pkg::CASE_4
		&& !verdict_i.abnormal |=> sw1 == t0_seq_pkg::PB_MORE && state == ST_SW1
		&& sw2 == $past(verdict_i.avail[7:0]))
		else $error("case 4 did not invite fetch");
	chk_case3_status: assert property (state == ST_FINAL && verdict_i.valid && kind == t0_seq_pkg::CASE_3
		|=> {sw1, sw2} == $past(verdict_i.sw))
		else $error("case 3 status wrong");
	chk_proc_case24: assert property (state == ST_SW1 && load_ok
		&& (sw1 == t0_seq_pkg::PB_MORE || sw1 == t0_seq_pkg::PB_WRONG_LE) |-> kind != t0_seq_pkg::CASE_3)
		else $error("retrieval byte in case 3");
	chk_fetch_case2: assert property (state == ST_VERDICT && verdict_i.valid
		&& hdr.ins == t0_seq_pkg::INS_GET_RESPONSE |=> kind == t0_seq_pkg::CASE_2)
		else $error("fetch not handled as case 2");
	chk_status_after_data: assert property (app_data_valid_i && app_data_ready_o && cnt == 9'h1
		|=> state == ST_SW1 && tx_valid_o && tx_data_o == $past(app_data_i))
		else $error("status not after data");

	cov_case2_data: cover property (state == ST_TXD ##1 state == ST_SW1);
	cov_resend: cover property (state == ST_SW1 && sw1 == t0_seq_pkg::PB_WRONG_LE);
	cov_case4_more: cover property (state == ST_FINAL && kind == t0_seq_pkg::CASE_4 ##1 state == ST_SW1);
	cov_abnormal: cover property (state == ST_VERDICT && verdict_i.valid && verdict_i.abnormal);
endmodule : t0_apdu_transport_sequencer

// >>> terminal_model.sv
// Purpose: terminal side of the T = 0 link, sends bytes and paces card output
// Assumes: one byte per cycle at most on the receive side
// Notes: slow_i lets the card wait three of four cycles
`timescale 1ns/1ns
module terminal_model (
	input wire logic clock_i,
	input wire logic slow_i,
	output t0_seq_pkg::byte_type rx_o,
	output logic ready_o
);
	logic [1:0] cnt = 2'h0;
	initial begin
		rx_o = '0;
	end
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(negedge clock_i);
			rx_o = {1'b1, b[i]};
		end
		@(negedge clock_i);
		// Released line shows the inverse, not a stale copy
		rx_o = {1'b0, ~rx_o.data};
	endtask : send
	always @(negedge clock_i) begin
		cnt <= cnt + 2'h1;
		ready_o <= !slow_i || cnt == 2'h0;
	end
endmodule : terminal_model

// >>> testbench.sv
// Purpose: self-checking bench of the card-side T = 0 sequencer
// Assumes: the application may stall its response data at random
// Notes: expected bytes are queued before each command
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic slow = 1'b0;
	logic tx_valid, tx_ready, hv, app_rdy;
	logic took = 1'b0;
	logic app_vld = 1'b1;
	logic [15:0] g = 16'h7b09;
	logic [7:0] tx_data, e;
	logic [15:0] r = 16'h7b09;
	logic [15:0] h = 16'h7b09;
	logic [7:0] q[$];
	logic [7:0] cq[$];
	t0_seq_pkg::byte_type rx, cmd;
	t0_seq_pkg::header_type hdr, hexp;
	t0_seq_pkg::verdict_type vd = '0;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 clock_i = ~clock_i;
	terminal_model u_terminal_model (.clock_i(clock_i), .slow_i(slow), .rx_o(rx), .ready_o(tx_ready));
	t0_apdu_transport_sequencer u_t0_apdu_transport_sequencer (.clock_i(clock_i), .rst_i(rst_i), .rx_i(rx),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .hdr_o(hdr), .hdr_valid_o(hv),
		.verdict_i(vd), .app_data_valid_i(app_vld), .app_data_i(r[7:0]), .app_data_ready_o(app_rdy),
		.cmd_data_o(cmd));
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt
	task automatic wrap_up;
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	always @(posedge clock_i) begin
		cycles++;
		took <= app_rdy && app_vld;
		if (!rst_i && tx_valid && tx_ready) begin
			e = q.size() != 0 ? q.pop_front() : 8'hxx;
			`CHK("tx_byte", e, tx_data)
		end
		if (!rst_i && cmd.valid) begin
			e = cq.size() != 0 ? cq.pop_front() : 8'hxx;
			`CHK("cmd_byte", e, cmd.data)
		end
		if (!rst_i && hv)
			`CHK("header", hexp, hdr)
		if (cycles > 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	always @(negedge clock_i) if (took) r <= nxt(r);
	// Random stalls of the application data source
	always @(negedge clock_i) begin
		g <= nxt(g);
		app_vld <= g[0] | g[1];
	end
	task automatic push(input logic [7:0] b[$]);
		foreach (b[i]) q.push_back(b[i]);
	endtask : push
	// Expected response data follows the same chain as app_data_i
	task automatic expd(input int n);
		logic [15:0] x;
		x = r;
		repeat (n) begin
			q.push_back(x[7:0]);
			x = nxt(x);
		end
	endtask : expd
	task automatic cmd_hdr(input logic [7:0] ins, input logic [7:0] p3, input logic fresh);
		h = nxt(h);
		if (fresh)
			hexp = {h[7:0], ins, h[15:8], h[7:0] ^ 8'h5a, p3};
		hexp.p3 = p3;
		u_terminal_model.send('{hexp.cla, hexp.ins, hexp.p1, hexp.p2, hexp.p3});
	endtask : cmd_hdr
	task automatic give(input t0_seq_pkg::case_type k, input logic ab, input logic [15:0] sw, input logic [8:0] av);
		repeat (2) @(negedge clock_i);
		vd = {1'b1, k, ab, sw, av};
		@(negedge clock_i);
		vd.valid = 1'b0;
	endtask : give
	task automatic settle;
		int n;
		n = 0;
		while ((q.size() != 0 || cq.size() != 0) && n < 2000) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 2000)
			fail_count++;
		repeat (3) @(negedge clock_i);
	endtask : settle
	task automatic cmd_body(input int n);
		logic [7:0] b[$];
		repeat (n) begin
			h = nxt(h);
			b.push_back(h[7:0]);
			cq.push_back(h[7:0]);
		end
		u_terminal_model.send(b);
	endtask : cmd_body
	task automatic c34(input logic [7:0] ins, p3, input t0_seq_pkg::case_type k, input logic ab,
		input logic [15:0] sw, input logic [7:0] e1, e2);
		push('{ins});
		cmd_hdr(ins, p3, 1'b1);
		give(k, 1'b0, 16'h9000, 9'h000);
		settle;
		cmd_body(p3);
		push('{e1, e2});
		give(k, ab, sw, 9'h008);
		settle;
	endtask : c34
	initial begin
		repeat (10) @(negedge clock_i);
		`CHK("reset_outputs", 44'h0, {tx_valid, hv, cmd.valid, app_rdy, hdr})
		rst_i = 1'b0;
		// exact then short request, second one with a stalling terminal
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			push('{8'ha4});
			expd(2);
			push('{s != 0 ? 8'h61 : 8'h90, s != 0 ? 8'h03 : 8'h00});
			cmd_hdr(8'ha4, 8'h02, 1'b1);
			give(t0_seq_pkg::CASE_2, 1'b0, 16'h9000, s != 0 ? 9'h005 : 9'h002);
			settle;
		end
		slow = 1'b0;
		// too long, then resend with the announced length
		push('{8'h6c, 8'h03});
		cmd_hdr(8'hb0, 8'h05, 1'b1);
		give(t0_seq_pkg::CASE_2, 1'b0, 16'h9000, 9'h003);
		settle;
		push('{8'hb0});
		expd(3);
		push('{8'h90, 8'h00});
		cmd_hdr(8'hb0, 8'h03, 1'b0);
		give(t0_seq_pkg::CASE_2, 1'b0, 16'h9000, 9'h003);
		settle;
		// zero length with less than a full block available
		push('{8'h6c, 8'h0a});
		cmd_hdr(8'hb0, 8'h00, 1'b1);
		give(t0_seq_pkg::CASE_2, 1'b0, 16'h9000, 9'h00a);
		settle;
		// abnormal case 2 gives status only
		push('{8'h6a, 8'h82});
		cmd_hdr(8'hb2, 8'h04, 1'b1);
		give(t0_seq_pkg::CASE_2, 1'b1, 16'h6a82, 9'h004);
		settle;
		// status to a case 3 header ends it, no data follows
		push('{8'h69, 8'h85});
		cmd_hdr(8'hd6, 8'h04, 1'b1);
		give(t0_seq_pkg::CASE_3, 1'b1, 16'h6985, 9'h000);
		settle;
		c34(8'hd6, 8'hff, t0_seq_pkg::CASE_3, 1'b0, 16'h9000, 8'h90, 8'h00);
		c34(8'h88, 8'h02, t0_seq_pkg::CASE_4, 1'b0, 16'h9000, 8'h61, 8'h08);
		push('{8'hc0});
		expd(8);
		push('{8'h90, 8'h00});
		cmd_hdr(8'hc0, 8'h08, 1'b1);
		give(t0_seq_pkg::CASE_4, 1'b0, 16'h9000, 9'h008);
		settle;
		// warning, then fetch with zero length and a full block
		c34(8'h88, 8'h01, t0_seq_pkg::CASE_4, 1'b1, 16'h6283, 8'h62, 8'h83);
		push('{8'hc0});
		expd(256);
		push('{8'h90, 8'h00});
		cmd_hdr(8'hc0, 8'h00, 1'b1);
		give(t0_seq_pkg::CASE_2, 1'b0, 16'h9000, 9'h100);
		settle;
		// error status ends a case 4 command without a fetch
		c34(8'h88, 8'h03, t0_seq_pkg::CASE_4, 1'b1, 16'h6a82, 8'h6a, 8'h82);
		wrap_up();
	end
endmodule : testbench
